// [core/psp_sram_port.sv]
// Pipelined synchronous SRAM port: load, two-edge data pipeline, suspend and deselect
`timescale 1ns/1ps
//
// Overview of operation
// - Suspend high ignores the edge, holds everything
// - Selected load edge captures address, direction, and lanes for writes
// - Read data two enabled edges after load
// - Back-to-back reads stream without idle cycles
// - Pending read completes despite later deselect
// - Pending write stored despite later deselect
// - Data pins high impedance after first edge
module psp_sram_port
  import psp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clock_suspend_n,
  input wire logic advance_or_load,
  input wire logic read_not_write,
  input wire logic chip_select_a_n,
  input wire logic chip_select_b,
  input wire logic chip_select_c_n,
  input wire logic output_enable_n,
  input wire logic [PSP_ADDR_W-1:0] address,
  input wire logic [PSP_LANES-1:0] byte_lane_write_n,
  input wire logic [PSP_DATA_W-1:0] dq_in,
  output logic [PSP_DATA_W-1:0] dq_out,
  output logic dq_oe
);

  psp_op_type load_op_r;
  psp_op_type load_op_nxt;
  psp_op_type xfer_op_r;
  psp_op_type xfer_op_nxt;
  logic [PSP_DATA_W-1:0] dq_out_r;
  logic [PSP_DATA_W-1:0] dq_out_nxt;
  logic oe_r;
  logic oe_nxt;
  logic edge_en;
  logic selected;
  logic load_req;
  logic mem_we;
  logic xfer_read;
  logic [PSP_DATA_W-1:0] mem_q;

  // Low on the suspend pin enables the edge
  assign edge_en = !clock_suspend_n;

  assign selected = !chip_select_a_n && chip_select_b && !chip_select_c_n;

  assign load_req = edge_en && !advance_or_load && selected;

  // Operation in its transfer slot on this edge
  assign xfer_read = xfer_op_r.valid && !xfer_op_r.write;

  // store regardless of current select state
  assign mem_we = edge_en && !rst && xfer_op_r.valid && xfer_op_r.write;

  // Storage; write data is sampled on the second enabled edge
  psp_mem_array u_mem (
    .sys_clk(sys_clk),
    .we(mem_we),
    .wr_addr(xfer_op_r.addr),
    .wr_lane_n(xfer_op_r.lane_n),
    .wr_data(dq_in),
    .rd_addr(xfer_op_r.addr),
    .rd_data(mem_q)
  );

  // The array is read from the transfer-slot address, so the output register
  // takes the word at the edge that empties the slot. A write in the slot lands
  // at that same edge, so reads and writes stay one word apart on the bus with
  // no turn-around cycle between them.
  // Pipeline next state; select only gates new loads, never pending ones
  always_comb begin
    load_op_nxt = load_op_r;
    xfer_op_nxt = xfer_op_r;
    dq_out_nxt = dq_out_r;
    oe_nxt = oe_r;
    if (rst) begin
      // bus released from the first edge on
      load_op_nxt = PSP_OP_IDLE;
      xfer_op_nxt = PSP_OP_IDLE;
      dq_out_nxt = PSP_DQ_RST;
      oe_nxt = PSP_OE_RST;
    end else if (edge_en) begin
      if (load_req) begin
        load_op_nxt.valid = 1'b1;
        load_op_nxt.write = !read_not_write;
        load_op_nxt.addr = address;
        load_op_nxt.lane_n = read_not_write ? PSP_LANES_OFF : byte_lane_write_n;
      end else begin
        // Deselect, stop or advance: no new operation
        load_op_nxt = PSP_OP_IDLE;
      end
      // pending operation moves on whatever the selects do
      xfer_op_nxt = load_op_r;
      // read data registered on second enabled edge
      if (xfer_read) begin
        dq_out_nxt = mem_q;
        oe_nxt = 1'b1;
      end else begin
        // release pins when nothing is due
        oe_nxt = 1'b0;
      end
    end
    // a suspended edge falls through and holds all state
  end

  // Pipeline registers
  always_ff @(posedge sys_clk) begin
    load_op_r <= load_op_nxt;
    xfer_op_r <= xfer_op_nxt;
    dq_out_r <= dq_out_nxt;
    oe_r <= oe_nxt;
  end

  // Output enable pin only masks drive; it does not touch the pipeline
  // The mask is combinational, so a controller can release the bus at once
  // while data already in the output register is kept for later
  assign dq_out = dq_out_r;
  assign dq_oe = oe_r && !output_enable_n;

  // Checks on the pipeline timing
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  logic rd_load;
  logic wr_load;
  assign rd_load = load_req && read_not_write;
  assign wr_load = load_req && !read_not_write;

  suspend_hold_a: assert property (
    clock_suspend_n |=> $stable(load_op_r) && $stable(xfer_op_r) && $stable(dq_out_r)
      && $stable(oe_r))
    else $error("state changed on a suspended edge");

  load_capture_a: assert property (
    load_req |=> load_op_r.valid && load_op_r.addr == $past(address)
      && load_op_r.write == !$past(read_not_write))
    else $error("load did not capture address or direction");

  // read due two enabled edges later
  read_latency_a: assert property (
    rd_load ##1 edge_en [*2] |=> oe_r && dq_out_r == $past(mem_q))
    else $error("read data missing two enabled edges after load");

  read_suspend_a: assert property (
    rd_load ##1 (!edge_en)[*2] ##1 edge_en [*2] |=> oe_r && dq_out_r == $past(mem_q))
    else $error("suspend shifted read latency");

  // streaming reads keep the bus driven
  read_stream_a: assert property (
    rd_load [*3] |=> oe_r ##1 oe_r)
    else $error("idle cycle inserted in read stream");

  // deselect does not cancel a pending read
  deselect_read_a: assert property (
    rd_load ##1 (edge_en && !selected) [*2] |=> oe_r && dq_out_r == $past(mem_q))
    else $error("pending read lost on deselect");

  // deselect does not cancel a pending write
  deselect_write_a: assert property (
    wr_load ##1 (edge_en && !selected) ##1 (edge_en && !selected) |-> mem_we)
    else $error("pending write not stored on deselect");

  // no pending read releases the pins
  idle_release_a: assert property (
    (edge_en && !xfer_read) |=> !oe_r)
    else $error("pins driven with no read pending");

  partial_select_a: assert property (
    (edge_en && !advance_or_load && (chip_select_a_n || !chip_select_b || chip_select_c_n))
      |=> !load_op_r.valid)
    else $error("load taken while deselected");

  // reset releases the pins at the next edge
  reset_release_a: assert property (
    @(posedge sys_clk) disable iff (1'b0) rst |=> !dq_oe)
    else $error("pins driven after reset edge");

  reset_clear_a: assert property (
    @(posedge sys_clk) disable iff (1'b0) rst |=> !load_op_r.valid && !xfer_op_r.valid)
    else $error("pipeline not cleared by reset");

  // no array write on a suspended edge
  suspend_write_a: assert property (
    clock_suspend_n |-> !mem_we)
    else $error("array written on a suspended edge");

  // lane strobes captured for writes only
  load_lanes_a: assert property (
    load_req |=> load_op_r.lane_n
      == ($past(read_not_write) ? PSP_LANES_OFF : $past(byte_lane_write_n)))
    else $error("lane strobes not captured at load");

  // advance or stop never starts an operation
  advance_noop_a: assert property (
    (edge_en && advance_or_load) |=> !load_op_r.valid)
    else $error("operation started without a load");

  xfer_advance_a: assert property (
    edge_en |=> xfer_op_r == $past(load_op_r))
    else $error("pending operation did not advance");

  // write stored at the second enabled edge
  write_latency_a: assert property (
    wr_load ##1 edge_en [*2] |-> mem_we && xfer_op_r.addr == $past(address, 2))
    else $error("write not stored two enabled edges after load");

  // Main scenarios
  read_stream_c: cover property (rd_load [*3] ##1 oe_r);
  suspend_read_c: cover property (rd_load ##1 !edge_en ##1 edge_en ##1 oe_r);
  deselect_write_c: cover property (wr_load ##1 (edge_en && !selected) ##1 mem_we);
  turnaround_c: cover property (rd_load ##1 wr_load ##1 rd_load);
  oe_mask_c: cover property (oe_r && output_enable_n);
endmodule

// [core/psp_pkg.sv]
// Package with widths, field layouts and pipeline types for the pipelined SRAM port
package psp_pkg;
  // Array organisation
  localparam int PSP_ADDR_W = 17;
  localparam int PSP_LANES = 4;
  localparam int PSP_LANE_W = 9;
  localparam int PSP_DATA_W = PSP_LANES * PSP_LANE_W;
  localparam int PSP_DEPTH = 131072;
  // Enabled edges from a load edge to its data transfer
  localparam int PSP_PIPE_EDGES = 2;
  // Reset values of pipeline and bus state
  localparam logic PSP_OE_RST = 1'b0;
  localparam logic [PSP_DATA_W-1:0] PSP_DQ_RST = 36'h0_0000_0000;
  localparam logic [PSP_LANES-1:0] PSP_LANES_OFF = 4'hf;

  // One operation as it travels down the pipeline
  typedef struct packed {
    logic valid;
    logic write;
    logic [PSP_ADDR_W-1:0] addr;
    logic [PSP_LANES-1:0] lane_n;
  } psp_op_type;

  localparam psp_op_type PSP_OP_IDLE = '{valid: 1'b0, write: 1'b0, addr: 17'h0_0000,
                                         lane_n: 4'hf};
endpackage

// [core/psp_mem_array.sv]
// Flip-flop storage array with per-lane write strobes and combinational read
`timescale 1ns/1ps
module psp_mem_array
  import psp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic we,
  input wire logic [PSP_ADDR_W-1:0] wr_addr,
  input wire logic [PSP_LANES-1:0] wr_lane_n,
  input wire logic [PSP_DATA_W-1:0] wr_data,
  input wire logic [PSP_ADDR_W-1:0] rd_addr,
  output logic [PSP_DATA_W-1:0] rd_data
);

  // One bank per byte lane so a masked lane keeps its old contents
  for (genvar g = 0; g < PSP_LANES; g++) begin : g_lane
    logic [PSP_LANE_W-1:0] bank [PSP_DEPTH];

    // Lane write; the strobe is active low
    always_ff @(posedge sys_clk) begin
      if (we && !wr_lane_n[g]) begin
        bank[wr_addr] <= wr_data[g*PSP_LANE_W +: PSP_LANE_W];
      end
    end

    // Contents are not reset, like a real array
    assign rd_data[g*PSP_LANE_W +: PSP_LANE_W] = bank[rd_addr];
  end
endmodule

// [dv/psp_ctrl_model.sv]
// Memory controller model that drives write data onto the shared bus
`timescale 1ns/1ps
module psp_ctrl_model
  import psp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clock_suspend_n,
  input wire logic wr_load,
  input wire logic [PSP_DATA_W-1:0] wr_word,
  output logic [PSP_DATA_W-1:0] dq_in
);
  logic [PSP_DATA_W:0] s1_r;
  logic [PSP_DATA_W:0] s2_r;
  initial dq_in = '0;
  // two-edge write pipe, advancing on enabled edges only
  always @(posedge sys_clk) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
    end else if (!clock_suspend_n) begin
      s2_r <= s1_r;
      s1_r <= {wr_load, wr_word};
    end
  end
  // Idle bus toggles, so a stale word is never mistaken for data
  always @(negedge sys_clk) begin
    dq_in <= s2_r[PSP_DATA_W] ? s2_r[PSP_DATA_W-1:0] : ~dq_in;
  end
endmodule

// [dv/psp_sram_port_tb.sv]
// Self-checking bench for the pipelined SRAM port
`timescale 1ns/1ps
module psp_sram_port_tb;
  import psp_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic sus_n = 1'b0;
  logic ld = 1'b1;
  logic rnw = 1'b1;
  logic [2:0] sel3 = 3'b101;
  logic [PSP_ADDR_W-1:0] addr = '0;
  logic [PSP_LANES-1:0] lanes = 4'hf;
  logic [PSP_DATA_W-1:0] wword = '0;
  logic [PSP_DATA_W-1:0] dq_in;
  logic [PSP_DATA_W-1:0] dq_out;
  logic wr_ld = 1'b0;
  logic oe_n = 1'b0;
  logic dq_oe;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  psp_sram_port u_psp_sram_port(.sys_clk(sys_clk), .rst(rst), .clock_suspend_n(sus_n),
    .advance_or_load(ld), .read_not_write(rnw), .chip_select_a_n(sel3[2]),
    .chip_select_b(sel3[1]), .chip_select_c_n(sel3[0]), .output_enable_n(oe_n),
    .address(addr), .byte_lane_write_n(lanes), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
  psp_ctrl_model u_psp_ctrl_model(.sys_clk(sys_clk), .rst(rst), .clock_suspend_n(sus_n),
    .wr_load(wr_ld), .wr_word(wword), .dq_in(dq_in));
  initial forever #12.5 sys_clk = ~sys_clk;
  // Hang guard: the whole run needs well under this many cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // One cycle: drive at a falling edge, return at the next falling edge
  task automatic step(input byte k, input logic [PSP_ADDR_W-1:0] a = '0,
      input logic [PSP_DATA_W-1:0] d = '0, input logic [2:0] sl = 3'b010,
      input logic [3:0] ln = 4'h0);
    sus_n = (k == "s");
    ld = (k == "n");
    rnw = (k != "w");
    sel3 = sl;
    addr = a;
    wword = d;
    lanes = ln;
    wr_ld = (k == "w") && (sl == 3'b010);
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic chk(input logic oe, input logic [PSP_DATA_W-1:0] d = '0);
    n_tests++;
    if (dq_oe !== oe || (oe && dq_out !== d)) begin
      n_mismatch++;
      $display("unexpected at %0t: %h/%h expected %h/%h", $time, dq_oe, dq_out, oe, d);
    end
  endtask
  // Writes and reads separated by ignored edges
  task automatic t_suspend;
    step("w", 5, 36'h1_2345_6789);
    step("s");
    step("w", 6, 36'h9_8765_4321);
    step("r", 5);
    step("r", 6);
    chk(1'b0);
    step("s");
    step("n");
    chk(1'b1, 36'h1_2345_6789);
    step("s");
    step("s");
    chk(1'b1, 36'h1_2345_6789);
    step("n");
    chk(1'b1, 36'h9_8765_4321);
    step("n");
    chk(1'b0);
    $display("test suspend done");
  endtask
  // Lane-masked write, then reads on consecutive edges
  task automatic t_stream;
    step("w", 8, 36'h1_1111_1111);
    step("n");
    step("w", 8, 36'h2_2222_2222, 3'b010, 4'h5);
    step("r", 8);
    step("r", 5);
    step("r", 6);
    chk(1'b1, 36'h2_2222_2222 & 36'hff803fe00 | 36'h1_1111_1111 & ~36'hff803fe00);
    step("n");
    chk(1'b1, 36'h1_2345_6789);
    step("n");
    chk(1'b1, 36'h9_8765_4321);
    $display("test stream done");
  endtask
  // Pending transfers finish while each select in turn is inactive
  task automatic t_desel;
    logic [2:0] pats [3] = '{3'b110, 3'b000, 3'b011};
    for (int i = 0; i < 3; i++) begin
      step("w", 10, 36'h3_0000_00a0 + i);
      step("d", 10, '0, pats[i]);
      step("d", 10, '0, pats[i]);
      step("r", 10);
      chk(1'b0);
      step("d", 10, '0, pats[i]);
      step("d", 10, '0, pats[i]);
      chk(1'b1, 36'h3_0000_00a0 + i);
      step("d", 10, '0, pats[i]);
      chk(1'b0);
    end
    $display("test deselect done");
  endtask
  // Read across two ignored edges, then the output mask over held data
  task automatic t_hold;
    step("r", 5);
    step("s");
    step("s");
    step("n");
    chk(1'b0);
    step("n");
    chk(1'b1, 36'h1_2345_6789);
    oe_n = 1'b1;
    step("s");
    chk(1'b0);
    oe_n = 1'b0;
    step("s");
    chk(1'b1, 36'h1_2345_6789);
    step("n");
    chk(1'b0);
    $display("test hold done");
  endtask
  initial begin
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    chk(1'b0);
    $display("test reset done");
    t_suspend();
    t_stream();
    t_desel();
    t_hold();
    wrap_up();
  end
endmodule
